// ---- design/pesm_bank.sv ----
// Per-port error status and error mask registers with summary error bits
// Functional notes
// - Rate mismatch sets status bit 2
// - Reading status clears rate mismatch flag
// - Status bit 1 shows reversed polarity
// - Status bit 0 shows jabber state
// - Jabber flag drops when jabber ends
// - Bits 15 to 3 read zero
// - One status and mask per port
// - Mask bit 2 enables rate mismatch reporting
// - Mask bit 1 enables polarity error reporting
// - Mask bit 0 enables jabber reporting
// - Summary error bits at 0,4,8,12
`timescale 1ns/1ps
module pesm_bank
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Management register access, one-cycle strobes
  input wire logic [1:0] reg_port_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Per-port line conditions
  input wire logic [3:0] rate_mismatch_i,
  input wire logic [3:0] polarity_rev_i,
  input wire logic [3:0] jabber_i,
  // Error summary bits, other summary bits are zero here
  output logic [15:0] summary_err_o
);
  // Access decode
  wire access_status;
  wire access_mask;
  wire read_status;
  wire write_mask;
  wire rdata_load;
  wire next_rvalid;

  // Per-port state gathered for the read mux
  wire [pesm_pkg::NUM_PORTS-1:0] rate_flag;
  wire [pesm_pkg::NUM_PORTS-1:0] pol_flag;
  wire [pesm_pkg::NUM_PORTS-1:0] jab_flag;
  wire [pesm_pkg::NUM_PORTS*pesm_pkg::FLAG_W-1:0] mask_all;

  // Read path and summary
  wire [pesm_pkg::FLAG_W-1:0] sel_status_flags;
  wire [pesm_pkg::FLAG_W-1:0] sel_mask_bits;
  wire [15:0] status_word;
  wire [15:0] mask_word;
  wire [15:0] next_rdata;
  wire [15:0] next_summary;

  function automatic logic hits_status(input logic [4:0] addr);
    hits_status = (addr == pesm_pkg::REG_STATUS);
  endfunction

  function automatic logic hits_mask(input logic [4:0] addr);
    hits_mask = (addr == pesm_pkg::REG_MASK);
  endfunction

  // Reserved bits forced here so no register can leak into them
  function automatic logic [15:0] pack_word(input logic [pesm_pkg::FLAG_W-1:0] v);
    pack_word = {pesm_pkg::RESERVED_ZERO, v};
  endfunction

  function automatic logic [pesm_pkg::FLAG_W-1:0] flag_word
  (
    input logic rate,
    input logic pol,
    input logic jab
  );
    logic [pesm_pkg::FLAG_W-1:0] w;
    w = pesm_pkg::MASK_RESET;
    w[pesm_pkg::BIT_RATE] = rate;
    w[pesm_pkg::BIT_POLARITY] = pol;
    w[pesm_pkg::BIT_JABBER] = jab;
    flag_word = w;
  endfunction

  assign access_status = hits_status(reg_addr_i);
  assign access_mask = hits_mask(reg_addr_i);
  // Status writes and writes to unmapped offsets are dropped without notice
  assign read_status = reg_rd_i && hits_status(reg_addr_i);
  assign write_mask = reg_wr_i && hits_mask(reg_addr_i);
  assign rdata_load = reg_rd_i;
  assign next_rvalid = reg_rd_i;

  genvar p;
  generate
    for (p = 0; p < pesm_pkg::NUM_PORTS; p++)
    begin : g_port
      // Per-port flags and mask
      logic rate_q;
      logic pol_q;
      logic jab_q;
      logic [pesm_pkg::FLAG_W-1:0] mask_q;
      wire sel_me;
      wire mask_load;
      wire next_rate;
      wire next_pol;
      wire next_jab;
      wire [pesm_pkg::FLAG_W-1:0] next_mask;
      wire [pesm_pkg::FLAG_W-1:0] flags;

      assign sel_me = (reg_port_i == 2'(p));
      assign mask_load = write_mask && sel_me;
      // Set wins over a clear on read in the same cycle, so no event is lost
      assign next_rate = rate_mismatch_i[p] || (rate_q && !(read_status && sel_me));
      assign next_pol = polarity_rev_i[p];
      assign next_jab = jabber_i[p];
      assign next_mask = mask_load ?
                         reg_wdata_i[pesm_pkg::BIT_RATE:pesm_pkg::BIT_JABBER] :
                         mask_q;
      assign flags = flag_word(rate_q, pol_q, jab_q);
      assign rate_flag[p] = rate_q;
      assign pol_flag[p] = pol_q;
      assign jab_flag[p] = jab_q;
      assign mask_all[p*pesm_pkg::FLAG_W +: pesm_pkg::FLAG_W] = mask_q;
      // A set mask bit lets its flag reach the summary
      assign next_summary[p*pesm_pkg::SUMMARY_STRIDE] = |(flags & mask_q);
      assign next_summary[p*pesm_pkg::SUMMARY_STRIDE+1 +: pesm_pkg::SUMMARY_STRIDE-1] = '0;

      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          rate_q <= 1'b0;
        end
        else
        begin
          rate_q <= next_rate;
        end
      end

      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          pol_q <= 1'b0;
        end
        else
        begin
          pol_q <= next_pol;
        end
      end

      // No latching of jabber, so the flag drops with the condition
      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          jab_q <= 1'b0;
        end
        else
        begin
          jab_q <= next_jab;
        end
      end

      always_ff @(posedge clk_sys_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          mask_q <= pesm_pkg::MASK_RESET;
        end
        else
        begin
          mask_q <= next_mask;
        end
      end
    end
  endgenerate

  assign sel_status_flags = flag_word(rate_flag[reg_port_i],
                                      pol_flag[reg_port_i],
                                      jab_flag[reg_port_i]);
  assign sel_mask_bits = mask_all[reg_port_i*pesm_pkg::FLAG_W +: pesm_pkg::FLAG_W];
  assign status_word = pack_word(sel_status_flags);
  assign mask_word = pack_word(sel_mask_bits);
  // Unmapped offsets read as zero
  assign next_rdata = access_status ? status_word :
                      access_mask ? mask_word :
                      pesm_pkg::STATUS_RESET;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= next_rvalid;
    end
  end

  // Registered read answer, held until the next read
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= pesm_pkg::STATUS_RESET;
    end
    else if (rdata_load)
    begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Registered summary, one cycle behind the flags
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      summary_err_o <= pesm_pkg::STATUS_RESET;
    end
    else
    begin
      summary_err_o <= next_summary;
    end
  end
endmodule

// ---- design/pesm_pkg.sv ----
// Package with register map and field layout of the port error status and mask bank
package pesm_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [4:0] REG_STATUS = 5'h13;
  localparam logic [4:0] REG_MASK = 5'h14;
  localparam logic [1:0] PORT_ID_W = 2'h3;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam int unsigned BIT_JABBER = 0;
  localparam int unsigned BIT_POLARITY = 1;
  localparam int unsigned BIT_RATE = 2;
  localparam int unsigned FLAG_W = 3;
  localparam int unsigned SUMMARY_STRIDE = 4;
  localparam logic [12:0] RESERVED_ZERO = 13'h0000;
endpackage

// ---- test/pesm_mgmt.sv ----
// Management controller model
`timescale 1ns/1ps
module pesm_mgmt
(
  // Clock
  input wire logic clk_sys_i,
  // Register access toward the bank
  output logic reg_rd_i,
  output logic reg_wr_i,
  output logic [1:0] reg_port_i,
  output logic [4:0] reg_addr_i,
  output logic [15:0] reg_wdata_i
);
  initial
  begin
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_port_i = 2'h0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
  end

  // One strobe cycle per access; the answer stands after the next edge
  task automatic acc(input logic r, input logic [1:0] p, input logic [4:0] a,
                     input logic [15:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_rd_i = r;
    reg_wr_i = !r;
    reg_port_i = p;
    reg_addr_i = a;
    reg_wdata_i = d & 16'h0007;
    @(posedge clk_sys_i);
    #1;
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b0;
  endtask
endmodule

// ---- test/pesm_properties.sv ----
// Checks on the bank ports
`timescale 1ns/1ps
module pesm_properties
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register access
  input wire logic [1:0] reg_port_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Line conditions and summary
  input wire logic [3:0] rate_mismatch_i,
  input wire logic [3:0] polarity_rev_i,
  input wire logic [3:0] jabber_i,
  input wire logic [15:0] summary_err_o
);
  logic [3:0] pol_d1;
  logic [3:0] jab_d1;
  wire pick_pol;
  wire pick_jab;

  // Line levels one cycle old, as the flags hold them
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pol_d1 <= 4'h0;
      jab_d1 <= 4'h0;
    end
    else
    begin
      pol_d1 <= polarity_rev_i;
      jab_d1 <= jabber_i;
    end
  end

  assign pick_pol = pol_d1[reg_port_i];
  assign pick_jab = jab_d1[reg_port_i];

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_status_read;
    reg_rd_i && (reg_addr_i == pesm_pkg::REG_STATUS);
  endsequence

  sequence s_answer;
    ##1 reg_rvalid_o;
  endsequence

  rv_on_a: assert property (reg_rd_i |-> s_answer) else $error("no read valid");
  rv_off_a: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
  rsv_zero_a: assert property (reg_rvalid_o |-> !reg_rdata_o[15:3]) else $error("reserved set");
  sum_gap_a: assert property (!(summary_err_o & 16'heeee)) else $error("summary gap set");
  pol_read_a: assert property (s_status_read |=> reg_rdata_o[pesm_pkg::BIT_POLARITY] == $past(pick_pol)) else $error("polarity bit wrong");
  jab_read_a: assert property (s_status_read |=> reg_rdata_o[pesm_pkg::BIT_JABBER] == $past(pick_jab)) else $error("jabber bit wrong");
endmodule
bind pesm_bank pesm_properties pesm_properties_i (.*);

// ---- test/tb.sv ----
// Bench for the error bank
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic reg_rd_i;
  logic reg_wr_i;
  logic [1:0] reg_port_i;
  logic [4:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic [15:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [15:0] summary_err_o;
  logic [3:0] rate_mismatch_i = 4'h0;
  logic [3:0] polarity_rev_i = 4'h2;
  logic [3:0] jabber_i = 4'h1;
  // Port 0 jabber, port 1 polarity, port 2 rate event, port 3 quiet
  logic [15:0] exp_status [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0000};
  int num_errors = 0;
  int compares = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  pesm_bank pesm_bank_i (.*);
  pesm_mgmt pesm_mgmt_i (.*);

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input string name, input logic [1:0] p, input logic [4:0] a,
                    input logic [15:0] e);
    pesm_mgmt_i.acc(1'b1, p, a, 16'h0000);
    chk(name, reg_rdata_o, e);
    chk({name, " valid"}, {15'h0000, reg_rvalid_o}, 16'h0001);
  endtask

  task automatic wrap_up;
    $display("%0d compares %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Tests need about 73 cycles; the limit of 1000 cycles allows about thirteen times that
  initial
  begin
    #50000;
    num_errors++;
    wrap_up;
  end

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    rate_mismatch_i = 4'h4;
    @(posedge clk_sys_i);
    #1;
    rate_mismatch_i = 4'h0;
    rd("status port 3", 2'd3, pesm_pkg::REG_STATUS, 16'h0000);
    rd("mask port 3", 2'd3, pesm_pkg::REG_MASK, 16'h0000);
    $display("test reset values done");

    for (int p = 0; p < 4; p++)
    begin
      pesm_mgmt_i.acc(1'b0, 2'(p), pesm_pkg::REG_MASK, 16'h0001 << p);
      rd("mask readback", 2'(p), pesm_pkg::REG_MASK, 16'h0007 & (16'h0001 << p));
      rd("status per port", 2'(p), pesm_pkg::REG_STATUS, exp_status[p]);
    end
    chk("summary masked", summary_err_o, 16'h0011);
    rd("status cleared", 2'd2, pesm_pkg::REG_STATUS, 16'h0000);
    $display("test per port done");

    fork
      rd("status during event", 2'd2, pesm_pkg::REG_STATUS, 16'h0000);
      begin
        @(posedge clk_sys_i);
        #1;
        rate_mismatch_i = 4'h4;
        @(posedge clk_sys_i);
        #1;
        rate_mismatch_i = 4'h0;
      end
    join
    @(posedge clk_sys_i);
    #1;
    chk("summary rate", summary_err_o, 16'h0111);
    rd("status set kept", 2'd2, pesm_pkg::REG_STATUS, 16'h0004);
    rd("status set cleared", 2'd2, pesm_pkg::REG_STATUS, 16'h0000);
    $display("test set over clear done");

    jabber_i = 4'h0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("summary jabber gone", summary_err_o, 16'h0010);
    rd("status jabber gone", 2'd0, pesm_pkg::REG_STATUS, 16'h0000);
    polarity_rev_i = 4'h8;
    rd("status polarity port 3", 2'd3, pesm_pkg::REG_STATUS, 16'h0002);
    rd("status polarity port 1", 2'd1, pesm_pkg::REG_STATUS, 16'h0000);
    chk("summary polarity unmasked", summary_err_o, 16'h0000);
    $display("test line levels done");

    pesm_mgmt_i.acc(1'b0, 2'd3, pesm_pkg::REG_MASK, 16'h0002);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("summary port 3", summary_err_o, 16'h1000);
    @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b0;
    #1;
    chk("summary in reset", summary_err_o, 16'h0000);
    @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    rd("mask after reset", 2'd3, pesm_pkg::REG_MASK, 16'h0000);
    rd("mask after reset", 2'd0, pesm_pkg::REG_MASK, 16'h0000);
    rd("status after reset", 2'd3, pesm_pkg::REG_STATUS, 16'h0002);
    pesm_mgmt_i.acc(1'b0, 2'd0, pesm_pkg::REG_MASK, 16'hffff);
    rd("mask reserved", 2'd0, pesm_pkg::REG_MASK, 16'h0007);
    pesm_mgmt_i.acc(1'b0, 2'd3, pesm_pkg::REG_STATUS, 16'h0007);
    rd("status after write", 2'd3, pesm_pkg::REG_STATUS, 16'h0002);
    $display("test mid-run reset done");
    wrap_up;
  end
endmodule
